// ---- awm_defs.vh ----
// Constants for the write-burst master: register map, fields, encodings
`ifndef AWM_DEFS_VH
`define AWM_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define AWM_OFS_CTRL   8'h00
`define AWM_OFS_ADDR   8'h04
`define AWM_OFS_ATTR   8'h08
`define AWM_OFS_ID     8'h0c
`define AWM_OFS_STAT   8'h10
`define AWM_OFS_BEAT   8'h14
`define AWM_WIN_SEL    2'h1
`define AWM_WIN_TOP    7:6
`define AWM_WIN_IDX    5:2

// ****************************************
// Control register bits
// ****************************************
`define AWM_CTRL_START 0
`define AWM_CTRL_CLR   1

// ****************************************
// Attribute register fields
// ****************************************
`define AWM_ATTR_LEN    3:0
`define AWM_ATTR_SIZE   10:8
`define AWM_ATTR_BURST  13:12
`define AWM_ATTR_LOCK   14
`define AWM_ATTR_CACHE  19:16
`define AWM_ATTR_PROT   22:20
`define AWM_ATTR_QOS    27:24
`define AWM_ATTR_REGION 31:28
`define AWM_ATTR_RST    32'h00001200

// ****************************************
// Status register fields
// ****************************************
`define AWM_STAT_BUSY  0
`define AWM_STAT_DONE  1
`define AWM_STAT_IDERR 2
`define AWM_STAT_RESP  5:4
`define AWM_STAT_BID   11:8

// ****************************************
// Burst type encodings
// ****************************************
`define AWM_BURST_FIXED 2'h0
`define AWM_BURST_INCR  2'h1
`define AWM_BURST_WRAP  2'h2

`endif

// ---- awm_mem.v ----
// Beat store: 16 entries of strobes and data, registered read
`timescale 1ns/1ns
module awm_mem (
  input  wire        clk_sys,
  input  wire        we,
  input  wire [3:0]  waddr,
  input  wire [35:0] wdata,
  input  wire [3:0]  raddr,
  output reg  [35:0] rdata_reg
);
  reg [35:0] mem [0:15];

  // Write port and registered read port
  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_reg <= mem[raddr];
  end
endmodule

// ---- awm_beat_addr.v ----
// Tracks the address of the current beat of a burst
`timescale 1ns/1ns
`include "awm_defs.vh"
module awm_beat_addr (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        load,
  input  wire [31:0] start_addr,
  input  wire [2:0]  size,
  input  wire [1:0]  burst,
  input  wire [3:0]  len,
  input  wire        step,
  output reg  [31:0] addr_reg
);
  wire [31:0] inc;
  wire [31:0] mask;
  wire [31:0] nxt_incr;
  wire [31:0] nxt_wrap;
  reg  [31:0] addr_next;

  // Beat size, wrap window and the two candidate next addresses
  assign inc      = 32'h1 << size;
  assign mask     = ({28'h0, len} + 32'h1) * inc - 32'h1;
  assign nxt_incr = (addr_reg & ~(inc - 32'h1)) + inc;
  assign nxt_wrap = (addr_reg & ~mask) | (nxt_incr & mask);

  // Next address chosen by burst type and beat size
  always @* begin
    addr_next = addr_reg;
    if (load) begin
      addr_next = start_addr;
    end else if (step) begin
      case (burst)
        `AWM_BURST_FIXED: addr_next = addr_reg;
        `AWM_BURST_WRAP:  addr_next = nxt_wrap;
        default:          addr_next = nxt_incr;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg <= 32'h0;
    end else begin
      addr_reg <= addr_next;
    end
  end
endmodule

// ---- awm_top.v ----
// Write-burst bus master steered by software over a Wishbone slave port
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "awm_defs.vh"

module awm_top (
  input  wire        clk_sys,
  input  wire        rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Bus reset
  output reg         aresetn,
  // Write address channel; no user sideband on any channel
  // Region and quality values come from the attribute register
  output reg  [3:0]  awid,
  output reg  [31:0] awaddr,
  output reg  [7:0]  awlen,
  output reg  [2:0]  awsize,
  output reg  [1:0]  awburst,
  output reg         awlock,
  output reg  [3:0]  awcache,
  output reg  [2:0]  awprot,
  output reg  [3:0]  awqos,
  output reg  [3:0]  awregion,
  output reg         awvalid,
  input  wire        awready,
  // Write data channel: fixed 32-bit data, no data tag
  // One strobe bit per byte lane of the data bus
  output reg  [31:0] wdata,
  output reg  [3:0]  wstrb,
  output reg         wlast,
  output reg         wvalid,
  input  wire        wready,
  // Write response channel
  input  wire [3:0]  bid,
  input  wire [1:0]  bresp,
  input  wire        bvalid,
  output reg         bready
);

  // ****************************************
  // State encodings
  // ****************************************
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_ADDR  = 6'h02;
  localparam [5:0] S_FETCH = 6'h04;
  localparam [5:0] S_LOAD  = 6'h08;
  localparam [5:0] S_DATA  = 6'h10;
  localparam [5:0] S_RESP  = 6'h20;

  // ****************************************
  // Declarations
  // ****************************************
  reg  [5:0]  state_reg;
  reg  [31:0] addr_reg;
  reg  [31:0] attr_reg;
  reg  [3:0]  id_reg;
  reg         done_reg;
  reg         iderr_reg;
  reg  [1:0]  resp_reg;
  reg  [3:0]  bid_reg;
  reg  [3:0]  beat_reg;
  wire        wb_req;
  wire        wb_wr;
  wire        win_hit;
  wire        busy;
  wire        aw_fire;
  wire        w_fire;
  wire        b_fire;
  wire        start;
  wire        clr;
  wire [35:0] mem_rdata;
  wire [31:0] beat_addr;
  reg  [31:0] rd_mux;

  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // Handshake and request decode
  // ****************************************
  assign wb_req  = wb_cyc_i & wb_stb_i;
  assign wb_wr   = wb_req & wb_we_i & wb_ack_o;
  assign win_hit = (wb_adr_i[`AWM_WIN_TOP] == `AWM_WIN_SEL);
  assign busy    = ~state_reg[0];
  assign aw_fire = awvalid & awready;
  assign w_fire  = wvalid & wready;
  assign b_fire  = bvalid & bready;
  assign start   = wb_wr & (wb_adr_i == `AWM_OFS_CTRL) &
                   wb_sel_i[0] & wb_dat_i[`AWM_CTRL_START] & ~busy;
  assign clr     = wb_wr & (wb_adr_i == `AWM_OFS_CTRL) &
                   wb_sel_i[0] & wb_dat_i[`AWM_CTRL_CLR];

  // ****************************************
  // Beat store and beat address tracker
  // ****************************************
  awm_mem u_mem (
    .clk_sys   (clk_sys),
    .we        (wb_wr & win_hit & ~busy),
    .waddr     (wb_adr_i[`AWM_WIN_IDX]),
    .wdata     ({wb_sel_i, wb_dat_i}),
    .raddr     (beat_reg),
    .rdata_reg (mem_rdata)
  );

  awm_beat_addr u_beat (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (start),
    .start_addr (addr_reg),
    .size       (attr_reg[`AWM_ATTR_SIZE]),
    .burst      (attr_reg[`AWM_ATTR_BURST]),
    .len        (attr_reg[`AWM_ATTR_LEN]),
    .step       (w_fire),
    .addr_reg   (beat_addr)
  );

  // ****************************************
  // Wishbone slave
  // ****************************************

  // Ack one cycle after request, dropped the cycle after
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // Read data mux; unmapped and window reads give zero
  always @* begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      `AWM_OFS_CTRL: rd_mux = {31'h0, busy};
      `AWM_OFS_ADDR: rd_mux = addr_reg;
      `AWM_OFS_ATTR: rd_mux = attr_reg;
      `AWM_OFS_ID:   rd_mux = {28'h0, id_reg};
      `AWM_OFS_STAT: rd_mux = {20'h0, bid_reg, 2'h0, resp_reg,
                               1'b0, iderr_reg, done_reg, busy};
      `AWM_OFS_BEAT: rd_mux = beat_addr;
      default:       rd_mux = 32'h0;
    endcase
  end

  // Software registers; frozen while a burst is in flight
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg <= 32'h0;
      attr_reg <= `AWM_ATTR_RST;
      id_reg   <= 4'h0;
    end else if (wb_wr & ~busy) begin
      if (wb_adr_i == `AWM_OFS_ADDR) begin
        addr_reg <= merge(addr_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `AWM_OFS_ATTR) begin
        attr_reg <= merge(attr_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `AWM_OFS_ID && wb_sel_i[0]) begin
        id_reg <= wb_dat_i[3:0];
      end
    end
  end

  // Sticky completion flags; a new answer wins over a clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_reg  <= 1'b0;
      iderr_reg <= 1'b0;
      resp_reg  <= 2'h0;
      bid_reg   <= 4'h0;
    end else if (b_fire) begin
      done_reg  <= 1'b1;
      iderr_reg <= (bid != awid);
      resp_reg  <= bresp;
      bid_reg   <= bid;
    end else if (clr) begin
      done_reg  <= 1'b0;
      iderr_reg <= 1'b0;
    end
  end

  // ****************************************
  // Bus reset output
  // ****************************************

  // Low during reset, released on a clock edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aresetn <= 1'b0;
    end else begin
      aresetn <= 1'b1;
    end
  end

  // ****************************************
  // Write address channel
  // ****************************************

  // Address and attributes latched at start, held until accepted
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awvalid  <= 1'b0;
      awid     <= 4'h0;
      awaddr   <= 32'h0;
      awlen    <= 8'h0;
      awsize   <= 3'h0;
      awburst  <= 2'h0;
      awlock   <= 1'b0;
      awcache  <= 4'h0;
      awprot   <= 3'h0;
      awqos    <= 4'h0;
      awregion <= 4'h0;
    end else if (start && aresetn) begin
      awvalid  <= 1'b1;
      awid     <= id_reg;
      awaddr   <= addr_reg;
      awlen    <= {4'h0, attr_reg[`AWM_ATTR_LEN]};
      awsize   <= attr_reg[`AWM_ATTR_SIZE];
      awburst  <= attr_reg[`AWM_ATTR_BURST];
      awlock   <= attr_reg[`AWM_ATTR_LOCK];
      awcache  <= attr_reg[`AWM_ATTR_CACHE];
      awprot   <= attr_reg[`AWM_ATTR_PROT];
      awqos    <= attr_reg[`AWM_ATTR_QOS];
      awregion <= attr_reg[`AWM_ATTR_REGION];
    end else if (aw_fire) begin
      awvalid  <= 1'b0;
    end
  end

  // ****************************************
  // Burst sequencer
  // ****************************************

  // Address first, then each beat, then the answer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      beat_reg  <= 4'h0;
      wvalid    <= 1'b0;
      wdata     <= 32'h0;
      wstrb     <= 4'h0;
      wlast     <= 1'b0;
      bready    <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          beat_reg <= 4'h0;
          if (start && aresetn) begin
            state_reg <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (aw_fire) begin
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          state_reg <= S_LOAD; // Store read in flight
        end
        S_LOAD: begin
          wvalid    <= 1'b1;
          wdata     <= mem_rdata[31:0];
          wstrb     <= mem_rdata[35:32];
          wlast     <= (beat_reg == attr_reg[`AWM_ATTR_LEN]);
          state_reg <= S_DATA;
        end
        S_DATA: begin
          if (w_fire) begin
            wvalid <= 1'b0;
            wlast  <= 1'b0;
            if (wlast) begin
              bready    <= 1'b1;
              state_reg <= S_RESP;
            end else begin
              beat_reg  <= beat_reg + 4'h1;
              state_reg <= S_FETCH;
            end
          end
        end
        S_RESP: begin
          if (b_fire) begin
            bready    <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          wvalid    <= 1'b0;
          bready    <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- awm_checker.sv ----
// Bus-side checks on the write-burst master ports
`timescale 1ns/1ns
module awm_checker (
  input wire        clk_sys,
  input wire        rst,
  input wire        aresetn,
  input wire [3:0]  awid,
  input wire [31:0] awaddr,
  input wire [7:0]  awlen,
  input wire        awvalid,
  input wire        awready,
  input wire [31:0] wdata,
  input wire [3:0]  wstrb,
  input wire        wlast,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire        bready
);
  reg [7:0] cnt_reg;
  reg [7:0] len_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // *****
  // Beats taken since the address handshake
  // *****
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      len_reg <= 8'h00;
    end else if (awvalid && awready) begin
      cnt_reg <= 8'h00;
      len_reg <= awlen;
    end else if (wvalid && wready) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // Two quiet data cycles
  sequence s_two_idle;
    !wvalid ##1 !wvalid;
  endsequence
  a_rst_quiet: assert property (!aresetn |-> !awvalid && !wvalid)
    else $error("valid high while bus reset low");
  a_aresetn_up: assert property (!aresetn && !rst |=> aresetn)
    else $error("bus reset not released");
  a_aw_hold: assert property (awvalid && !awready |=> awvalid
    && $stable(awaddr) && $stable(awid) && $stable(awlen))
    else $error("address request changed before ready");
  a_w_hold: assert property (wvalid && !wready |=> wvalid
    && $stable(wdata) && $stable(wstrb) && $stable(wlast))
    else $error("data beat changed before ready");
  a_aw_to_w: assert property (awvalid && awready |=>
    s_two_idle ##1 wvalid) else $error("first beat timing wrong");
  a_data_gap: assert property (wvalid && wready && !wlast |=>
    s_two_idle ##1 wvalid) else $error("next beat timing wrong");
  a_last_mark: assert property (wvalid |->
    wlast == (cnt_reg == len_reg)) else $error("last flag misplaced");
  a_resp_wait: assert property ($rose(bready) |->
    $past(wvalid && wready && wlast)) else $error("early answer ready");
  a_resp_take: assert property (bready |=>
    bready != $past(bvalid)) else $error("answer ready wrong");
endmodule
bind awm_top awm_checker awm_checker_inst (.clk_sys(clk_sys), .rst(rst),
  .aresetn(aresetn), .awid(awid), .awaddr(awaddr), .awlen(awlen),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wlast(wlast), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready));

// ---- awm_slave_model.sv ----
// Write-channel slave model that records bursts and answers them
`timescale 1ns/1ns
module awm_slave_model (
  input  wire        clk_sys,
  input  wire        aresetn,
  input  wire        slow,
  input  wire        bad_id,
  input  wire [1:0]  resp_code,
  input  wire [3:0]  awid,
  input  wire [31:0] awaddr,
  input  wire [7:0]  awlen,
  input  wire [2:0]  awsize,
  input  wire [1:0]  awburst,
  input  wire        awlock,
  input  wire [3:0]  awcache,
  input  wire [2:0]  awprot,
  input  wire [3:0]  awqos,
  input  wire [3:0]  awregion,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wlast,
  input  wire        wvalid,
  output wire        wready,
  output reg  [3:0]  bid,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready
);
  reg [31:0] attr_q, addr_q;
  reg [31:0] bdat [0:15];
  reg [3:0]  bstb [0:15];
  reg [3:0]  id_q, naw;
  reg [4:0]  nbeat;
  reg        tgl;
  // Ready every cycle, or every other cycle when slow
  assign awready = !slow || tgl;
  assign wready  = !slow || tgl;
  // Capture, count beats and answer the write
  always @(posedge clk_sys or negedge aresetn) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      tgl    <= 1'b0;
      nbeat  <= 5'h00;
      naw    <= 4'h0;
    end else begin
      tgl <= ~tgl;
      if (awvalid && awready) begin
        attr_q <= {awregion, awqos, 1'b0, awprot, awcache, 1'b0, awlock,
                   awburst, 1'b0, awsize, awlen};
        addr_q <= awaddr;
        id_q   <= awid;
        naw    <= naw + 4'h1;
        nbeat  <= 5'h00;
      end
      if (wvalid && wready) begin
        bdat[nbeat[3:0]] <= wdata;
        bstb[nbeat[3:0]] <= wstrb;
        nbeat <= nbeat + 5'h01;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (wvalid && wready && wlast) begin
        bvalid <= 1'b1;
        bid    <= id_q ^ {3'h0, bad_id};
        bresp  <= resp_code;
      end else if (!bvalid) begin
        bid   <= ~bid;
        bresp <= ~bresp;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the write-burst master
`timescale 1ns/1ns
`include "awm_defs.vh"
module tb_top;
  reg         clk_sys = 1'b0, rst = 1'b1;
  reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [31:0] wb_dat_i = 32'h0, rdv;
  reg  [3:0]  wb_sel_i = 4'h0;
  reg         slow = 1'b0, bad_id = 1'b0;
  reg  [1:0]  resp_code = 2'h0;
  wire [31:0] wb_dat_o, awaddr, wdata;
  wire        wb_ack_o, aresetn, awlock, awvalid, awready;
  wire        wlast, wvalid, wready, bvalid, bready;
  wire [3:0]  awid, awcache, awqos, awregion, wstrb, bid;
  wire [7:0]  awlen;
  wire [2:0]  awsize, awprot;
  wire [1:0]  awburst, bresp;
  integer     err_total, total_checks;
  always #5 clk_sys = ~clk_sys;
  awm_top awm_top_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .aresetn(aresetn), .awid(awid), .awaddr(awaddr),
    .awlen(awlen), .awsize(awsize), .awburst(awburst), .awlock(awlock),
    .awcache(awcache), .awprot(awprot), .awqos(awqos),
    .awregion(awregion), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid),
    .wready(wready), .bid(bid), .bresp(bresp), .bvalid(bvalid),
    .bready(bready));
  awm_slave_model awm_slave_model_inst (.clk_sys(clk_sys),
    .aresetn(aresetn), .slow(slow), .bad_id(bad_id),
    .resp_code(resp_code), .awid(awid), .awaddr(awaddr), .awlen(awlen),
    .awsize(awsize), .awburst(awburst), .awlock(awlock),
    .awcache(awcache), .awprot(awprot), .awqos(awqos),
    .awregion(awregion), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid),
    .wready(wready), .bid(bid), .bresp(bresp), .bvalid(bvalid),
    .bready(bready));
  // Compare and count
  task chk(input [79:0] nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task wb_io(input we, input [7:0] adr, input [31:0] dat,
             input [3:0] sel, output [31:0] rd);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1) @(posedge clk_sys);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // Fill beats, start, wait, then check status and what the slave saw
  task burst(input [1:0] bt, input [3:0] len, input [1:0] rc,
             input [3:0] id, input sl, input bad);
    integer    i;
    reg [31:0] attr, addr;
    begin
      attr = {id, ~id, 1'b0, id[2:0], ~id, 1'b0, id[0], bt, 1'b0, 3'h2,
              4'h0, len};
      addr = 32'h80000040 + {id, 8'h00};
      slow      <= sl;
      bad_id    <= bad;
      resp_code <= rc;
      wb_io(1'b1, `AWM_OFS_CTRL, 32'h2, 4'h1, rdv);
      wb_io(1'b0, `AWM_OFS_STAT, 32'h0, 4'hf, rdv);
      chk("done_clr", 32'h0, rdv & 32'h6);
      for (i = 0; i <= len; i = i + 1)
        wb_io(1'b1, {`AWM_WIN_SEL, i[3:0], 2'h0}, 32'hc0de0000 + i * 257,
              i[3:0] ^ 4'ha, rdv);
      wb_io(1'b1, `AWM_OFS_ADDR, addr, 4'hf, rdv);
      wb_io(1'b1, `AWM_OFS_ATTR, attr, 4'hf, rdv);
      wb_io(1'b1, `AWM_OFS_ID, {28'h0, id}, 4'h1, rdv);
      wb_io(1'b1, `AWM_OFS_CTRL, 32'h1, 4'h1, rdv);
      if (sl) begin
        wb_io(1'b1, `AWM_OFS_ATTR, ~attr, 4'hf, rdv);
        wb_io(1'b1, `AWM_OFS_CTRL, 32'h1, 4'h1, rdv);
      end
      rdv = 32'h1;
      while (rdv[0] !== 1'b0)
        wb_io(1'b0, `AWM_OFS_STAT, 32'h0, 4'hf, rdv);
      chk("stat", {20'h0, id ^ {3'h0, bad}, 2'h0, rc, 1'b0, bad, 2'h2},
          rdv);
      wb_io(1'b0, `AWM_OFS_ATTR, 32'h0, 4'hf, rdv);
      chk("attr", attr, rdv);
      wb_io(1'b0, `AWM_OFS_BEAT, 32'h0, 4'hf, rdv);
      chk("beat_addr", (bt == `AWM_BURST_INCR) ?
          addr + {26'h0, len, 2'h0} + 32'h4 : addr, rdv);
      chk("aw_attr", attr, awm_slave_model_inst.attr_q);
      chk("aw_addr", addr, awm_slave_model_inst.addr_q);
      chk("beats", {28'h0, len} + 32'h1,
          {27'h0, awm_slave_model_inst.nbeat});
      for (i = 0; i <= len; i = i + 1) begin
        chk("wdata", 32'hc0de0000 + i * 257,
            awm_slave_model_inst.bdat[i]);
        chk("wstrb", {28'h0, i[3:0] ^ 4'ha},
            {28'h0, awm_slave_model_inst.bstb[i]});
      end
    end
  endtask
  // Verdict and end of run
  task end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("aresetn", 32'h1, {31'h0, aresetn});
    wb_io(1'b0, `AWM_OFS_ATTR, 32'h0, 4'hf, rdv);
    chk("attr_rst", `AWM_ATTR_RST, rdv);
    wb_io(1'b1, 8'h20, 32'hffffffff, 4'hf, rdv);
    wb_io(1'b0, 8'h20, 32'h0, 4'hf, rdv);
    chk("unmapped", 32'h0, rdv);
    burst(`AWM_BURST_FIXED, 4'h0, 2'h0, 4'h3, 1'b0, 1'b0);
    burst(`AWM_BURST_INCR, 4'hf, 2'h1, 4'h5, 1'b1, 1'b0);
    burst(`AWM_BURST_WRAP, 4'h3, 2'h2, 4'h9, 1'b1, 1'b1);
    burst(`AWM_BURST_INCR, 4'h1, 2'h3, 4'ha, 1'b0, 1'b0);
    chk("bursts", 32'h4, {28'h0, awm_slave_model_inst.naw});
    end_sim;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total = err_total + 1;
    end_sim;
  end
endmodule
